// >>> smrd_asserts.sv
// Purpose: Link and mode decode checks beside the link
// Assumes: Posted latency 0 for the latency checks
// Notes:   Plain inputs, instantiated by the bench
`timescale 1ns/1ps
module smrd_asserts (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                cke,
	input wire smrd_pkg::smrd_cmd_t cmd,
	input wire logic [2:0]          bank,
	input wire logic [12:0]         addr,
	input wire logic                rvalid,
	input wire logic [2:0]          posted_extra_latency,
	input wire logic                burst_len8,
	input wire logic                burst_interleave,
	input wire logic [2:0]          column_latency,
	input wire logic [3:0]          recovery_cycles,
	input wire logic                loop_reset_pulse,
	input wire logic                precharge_start
);
	logic ld;
	logic rd;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign ld = cke && cmd == smrd_pkg::SMRD_LOAD && bank == 3'h0 && !addr[7];
	assign rd = cke && cmd == smrd_pkg::SMRD_READ && posted_extra_latency == 3'h0;
	AST_LOAD_STORE: assert property (
		ld |=> column_latency == $past(addr[6:4])
		&& burst_interleave == $past(addr[3])) else $error("load fields");
	AST_BURST_SIZE: assert property (
		ld |=> burst_len8 == ($past(addr[2:0]) == 3'h3)) else $error("size");
	AST_WR_CODE: assert property (
		ld |=> recovery_cycles == {1'b0, $past(addr[11:9])} + 4'h1)
		else $error("recovery");
	AST_DLL_PULSE: assert property (
		ld && addr[8] |=> loop_reset_pulse ##1 !loop_reset_pulse)
		else $error("dll pulse");
	AST_DLL_CLEAR: assert property (
		ld && !addr[8] |=> !loop_reset_pulse) else $error("dll stray");
	AST_RD_CL3: assert property (
		rd && column_latency == 3'h3 && !burst_len8
		|-> !rvalid[*4] ##1 rvalid[*4] ##1 !rvalid) else $error("cl3 read");
	AST_RD_BL8: assert property (
		rd && column_latency == 3'h5 && burst_len8
		|-> !rvalid[*6] ##1 rvalid[*8] ##1 !rvalid) else $error("bl8 read");
	AST_AUTO_PRE: assert property (
		cke && cmd == smrd_pkg::SMRD_WRITE && addr[10] && !burst_len8
		&& column_latency == 3'h3 && recovery_cycles == 4'h2
		&& posted_extra_latency == 3'h0
		|-> !precharge_start[*8] ##1 precharge_start ##1 !precharge_start)
		else $error("precharge");
endmodule : smrd_asserts

// >>> smrd_burst_seq.sv
// Purpose: Column of one burst beat from start column and mode
// Assumes: Beat index counts 0 up to burst length minus one
// Notes:   Purely combinational
`timescale 1ns/1ps
module smrd_burst_seq #(
	parameter int COL_W = 4
) (
	input  wire logic [COL_W-1:0] start,
	input  wire logic [2:0]       beat,
	input  wire logic             bl8,
	input  wire logic             interleave,
	output logic      [COL_W-1:0] col
);
	logic [1:0] low;

	initial begin
		if (COL_W < 4)
			$error("smrd_burst_seq: start column too narrow");
	end

	// ------------------------------------------------------------
	// Order within the block
	// ------------------------------------------------------------
	// xor ordering when interleaved, wrapping add when sequential
	assign low = interleave ? (start[1:0] ^ beat[1:0])
		: (start[1:0] + beat[1:0]);
	assign col = {start[COL_W-1:3], bl8 ? (start[2] ^ beat[2]) : start[2],
		low};
endmodule : smrd_burst_seq

// >>> smrd_ctrl.sv
// Purpose: Controller end: APB orders turned into link commands
// Assumes: Software writes ADDR, WDATA, CFG before CMD
// Notes:   CMD writes while busy are ignored
`timescale 1ns/1ps
module smrd_ctrl #(
	parameter int DATA_W = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	smrd_link_if.ctl         link
);
	localparam logic [7:0] LOCK_INIT = 8'(smrd_pkg::DLL_LOCK_CYC);
	localparam logic [3:0] MLW = 4'(smrd_pkg::MODE_LOAD_WAIT);
	localparam logic [2:0] WR_CODE = 3'(smrd_pkg::WR_CYC - 1);

	initial begin
		if (DATA_W < 1 || DATA_W > 32 || smrd_pkg::WR_CYC < 2 ||
			smrd_pkg::WR_CYC > 8)
			$error("smrd_ctrl: unsupported parameters");
	end

	typedef enum {HS_IDLE, HS_PEND, HS_WAIT, HS_BURST} smrd_ctl_st_t;

	function automatic logic mapped(input logic [7:0] a);
		mapped = a == smrd_pkg::CMD_OFS || a == smrd_pkg::ADDR_OFS ||
			a == smrd_pkg::WDATA_OFS || a == smrd_pkg::RDATA_OFS ||
			a == smrd_pkg::STAT_OFS || a == smrd_pkg::CFG_OFS;
	endfunction : mapped

	smrd_ctl_st_t        st_r, st_nxt;
	smrd_pkg::smrd_cmd_t op_r, op_nxt, cmd_r, cmd_nxt;
	logic [2:0]          obank_r, obank_nxt, lbank_r, lbank_nxt;
	logic [12:0]         addr_r, addr_nxt, laddr_r, laddr_nxt;
	logic [DATA_W-1:0]   wbase_r, wbase_nxt, wdata_r, wdata_nxt;
	logic [DATA_W-1:0]   rd_r, rd_nxt;
	logic                err_r, err_nxt, cke_r, cke_nxt;
	logic [2:0]          pxl_r, pxl_nxt, lat_r, lat_nxt, beat_r, beat_nxt;
	logic                bl8_r, bl8_nxt, wr_r, wr_nxt;
	logic [7:0]          open_r, open_nxt, dllw_r, dllw_nxt;
	logic [3:0]          gap_r, gap_nxt, cnt_r, cnt_nxt;
	logic [31:0]         prdata_r, prdata_nxt;
	logic                wacc, busy;

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	assign wacc    = psel && penable && pwrite && mapped(paddr);
	assign busy    = st_r != HS_IDLE || gap_r != 4'h0;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign prdata  = prdata_r;

	always_comb begin
		prdata_nxt = prdata_r;
		if (psel && !penable) begin
			case (paddr)
				smrd_pkg::ADDR_OFS:  prdata_nxt = {19'h0, addr_r};
				smrd_pkg::WDATA_OFS: prdata_nxt = 32'(wbase_r);
				smrd_pkg::RDATA_OFS: prdata_nxt = 32'(rd_r);
				smrd_pkg::STAT_OFS:
					prdata_nxt = {29'h0, err_r, dllw_r != 8'h00, busy};
				smrd_pkg::CFG_OFS:   prdata_nxt = {28'h0, pxl_r, cke_r};
				default:             prdata_nxt = 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	assign link.cke   = cke_r;
	assign link.cmd   = cmd_r;
	assign link.bank  = lbank_r;
	assign link.addr  = laddr_r;
	assign link.wdata = wdata_r;

	always_comb begin
		st_nxt = st_r;  op_nxt = op_r;  obank_nxt = obank_r;
		addr_nxt = addr_r;  wbase_nxt = wbase_r;  cke_nxt = cke_r;
		pxl_nxt = pxl_r;  lat_nxt = lat_r;  bl8_nxt = bl8_r;
		err_nxt = err_r;
		open_nxt = open_r;  wr_nxt = wr_r;  cnt_nxt = cnt_r;
		beat_nxt = beat_r;  lbank_nxt = lbank_r;  laddr_nxt = laddr_r;
		wdata_nxt = wdata_r;
		cmd_nxt  = smrd_pkg::SMRD_NOP;
		rd_nxt   = link.rvalid ? link.rdata : rd_r;
		dllw_nxt = (dllw_r != 8'h00) ? dllw_r - 8'h01 : dllw_r;
		gap_nxt  = (gap_r != 4'h0) ? gap_r - 4'h1 : gap_r;
		if (wacc && paddr == smrd_pkg::ADDR_OFS)
			addr_nxt = pwdata[12:0];
		if (wacc && paddr == smrd_pkg::WDATA_OFS)
			wbase_nxt = pwdata[DATA_W-1:0];
		if (wacc && paddr == smrd_pkg::CFG_OFS) begin
			cke_nxt = pwdata[0];
			pxl_nxt = pwdata[smrd_pkg::CFG_PXL_LSB+:3];
		end
		case (st_r)
			HS_IDLE: begin
				if (wacc && paddr == smrd_pkg::CMD_OFS && !busy) begin
					op_nxt    = smrd_pkg::smrd_cmd_t'(pwdata[2:0]);
					obank_nxt = pwdata[smrd_pkg::CMD_BANK_LSB+:3];
					err_nxt   = 1'b0;
					st_nxt    = HS_PEND;
				end
			end
			HS_PEND: begin
				if (gap_r == 4'h0 && !(op_r == smrd_pkg::SMRD_READ &&
					dllw_r != 8'h00)) begin
					st_nxt    = HS_IDLE;
					cmd_nxt   = op_r;
					lbank_nxt = obank_r;
					laddr_nxt = addr_r;
					case (op_r)
						smrd_pkg::SMRD_LOAD: begin
							gap_nxt = MLW;
							if (obank_r == 3'h0) begin
								if (|open_r || addr_r[smrd_pkg::LAT_LSB+:3] <
									smrd_pkg::LAT_MIN) begin
									err_nxt = 1'b1;
									cmd_nxt = smrd_pkg::SMRD_NOP;
									gap_nxt = 4'h0;
								end else begin
									laddr_nxt[smrd_pkg::TM_BIT] = 1'b0;
									laddr_nxt[smrd_pkg::WR_LSB+:3] = WR_CODE;
									lat_nxt = addr_r[smrd_pkg::LAT_LSB+:3];
									bl8_nxt = addr_r[2:0] ==
										smrd_pkg::BL8_CODE;
									if (addr_r[smrd_pkg::DLL_BIT])
										dllw_nxt = LOCK_INIT;
								end
							end
						end
						smrd_pkg::SMRD_ACT: open_nxt[obank_r] = 1'b1;
						smrd_pkg::SMRD_PRE: begin
							if (addr_r[smrd_pkg::AP_BIT])
								open_nxt = 8'h00;
							else
								open_nxt[obank_r] = 1'b0;
						end
						smrd_pkg::SMRD_READ, smrd_pkg::SMRD_WRITE: begin
							wr_nxt  = op_r == smrd_pkg::SMRD_WRITE;
							cnt_nxt = smrd_pkg::smrd_lat(pxl_r, lat_r,
								op_r == smrd_pkg::SMRD_WRITE);
							st_nxt  = HS_WAIT;
							if (op_r == smrd_pkg::SMRD_WRITE &&
								addr_r[smrd_pkg::AP_BIT])
								open_nxt[obank_r] = 1'b0;
						end
						default: cmd_nxt = smrd_pkg::SMRD_NOP;
					endcase
				end
			end
			HS_WAIT: begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1) begin
					wdata_nxt = wbase_r;
					beat_nxt  = 3'h1;
					st_nxt    = HS_BURST;
				end
			end
			HS_BURST: begin
				wdata_nxt = wbase_r + DATA_W'(beat_r);
				beat_nxt  = beat_r + 3'h1;
				if (beat_r == smrd_pkg::smrd_last(bl8_r))
					st_nxt = HS_IDLE;
			end
			default: st_nxt = HS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= HS_IDLE;  op_r <= smrd_pkg::SMRD_NOP;
			cmd_r <= smrd_pkg::SMRD_NOP;  obank_r <= 3'h0;
			lbank_r <= 3'h0;  addr_r <= 13'h0000;  laddr_r <= 13'h0000;
			wbase_r <= '0;  wdata_r <= '0;  rd_r <= '0;  err_r <= 1'b0;
			cke_r <= 1'b0;  pxl_r <= 3'h0;
			lat_r <= smrd_pkg::MR_RESET[smrd_pkg::LAT_LSB+:3];
			bl8_r <= 1'b0;  wr_r <= 1'b0;  beat_r <= 3'h0;
			open_r <= 8'h00;  dllw_r <= 8'h00;  gap_r <= 4'h0;
			cnt_r <= 4'h0;  prdata_r <= 32'h0;
		end else begin
			st_r <= st_nxt;  op_r <= op_nxt;  cmd_r <= cmd_nxt;
			obank_r <= obank_nxt;  lbank_r <= lbank_nxt;
			addr_r <= addr_nxt;  laddr_r <= laddr_nxt;
			wbase_r <= wbase_nxt;  wdata_r <= wdata_nxt;  rd_r <= rd_nxt;
			err_r <= err_nxt;  cke_r <= cke_nxt;  pxl_r <= pxl_nxt;
			lat_r <= lat_nxt;  bl8_r <= bl8_nxt;  wr_r <= wr_nxt;
			beat_r <= beat_nxt;  open_r <= open_nxt;  dllw_r <= dllw_nxt;
			gap_r <= gap_nxt;  cnt_r <= cnt_nxt;  prdata_r <= prdata_nxt;
		end
	end
endmodule : smrd_ctrl

// >>> smrd_device.sv
// Purpose: Memory end: mode register decode, burst order, latencies
// Assumes: Controller keeps mode loads, lockouts and reserved codes
// Notes:   One burst at a time; reads and writes during a burst are dropped
`timescale 1ns/1ps
module smrd_device #(
	parameter int COL_W  = 4,
	parameter int DATA_W = 16
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	smrd_link_if.dev        link,
	input  wire logic [2:0] posted_extra_latency,
	output logic            burst_len8,
	output logic            burst_interleave,
	output logic [2:0]      column_latency,
	output logic [3:0]      recovery_cycles,
	output logic            powerdown_slow_exit,
	output logic            test_mode,
	output logic            loop_reset_pulse,
	output logic            loop_locked,
	output logic            read_ready,
	output logic            loop_frozen,
	output logic            precharge_start
);
	localparam logic [7:0] LOCK_INIT = 8'(smrd_pkg::DLL_LOCK_CYC);
	localparam logic [3:0] FAST_X    = 4'(smrd_pkg::FAST_EXIT_CYC);
	localparam logic [3:0] SLOW_X    = 4'(smrd_pkg::SLOW_EXIT_CYC);
	localparam logic [3:0] PRE_X     = 4'(smrd_pkg::PRE_EXIT_CYC);

	initial begin
		if (COL_W < 4 || COL_W > 10 || DATA_W < 1 ||
			smrd_pkg::DLL_LOCK_CYC > 255)
			$error("smrd_device: unsupported parameters");
	end

	typedef enum {DS_IDLE, DS_WAIT, DS_BURST} smrd_dev_st_t;

	smrd_dev_st_t       st_r, st_nxt;
	logic [3:0]         cnt_r, cnt_nxt;
	logic [2:0]         beat_r, beat_nxt;
	logic [COL_W-1:0]   start_r, start_nxt;
	logic [2:0]         bank_r, bank_nxt;
	logic               wr_r, wr_nxt;
	logic               ap_r, ap_nxt;
	logic [3:0]         apc_r, apc_nxt;
	logic               pre_r, pre_nxt;
	logic [DATA_W-1:0]  rdata_r, rdata_nxt;
	logic               rvalid_r, rvalid_nxt;
	logic [12:0]        mr_r, mr_nxt;
	logic               tm_r, tm_nxt;
	logic [7:0]         lock_r, lock_nxt;
	logic [7:0]         open_r, open_nxt;
	logic               pd_r, pd_nxt;
	logic               pda_r, pda_nxt;
	logic               pds_r, pds_nxt;
	logic [3:0]         exit_r, exit_nxt;
	logic [DATA_W-1:0]  mem [0:(1<<COL_W)-1];
	logic               take;
	logic               act;
	logic [2:0]         beat_idx;
	logic [COL_W-1:0]   col;

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	assign take = link.cke && !pd_r;
	assign burst_len8       = mr_r[2:0] == smrd_pkg::BL8_CODE;
	assign burst_interleave = mr_r[smrd_pkg::BT_BIT];
	assign column_latency   = mr_r[smrd_pkg::LAT_LSB+:3];
	assign recovery_cycles  = {1'b0, mr_r[smrd_pkg::WR_LSB+:3]} + 4'h1;
	assign powerdown_slow_exit = mr_r[smrd_pkg::PD_BIT];
	assign test_mode        = tm_r;
	assign loop_reset_pulse = mr_r[smrd_pkg::DLL_BIT];
	assign loop_locked      = lock_r == 8'h00 && !loop_reset_pulse;
	assign read_ready       = loop_locked && exit_r == 4'h0 && !pd_r;
	assign loop_frozen      = pd_r && pds_r;
	assign precharge_start  = pre_r;
	assign link.rdata       = rdata_r;
	assign link.rvalid      = rvalid_r;

	// ------------------------------------------------------------
	// Mode register
	// ------------------------------------------------------------
	always_comb begin
		mr_nxt   = mr_r;
		tm_nxt   = tm_r;
		lock_nxt = lock_r;
		mr_nxt[smrd_pkg::DLL_BIT] = 1'b0;
		if (lock_r != 8'h00)
			lock_nxt = lock_r - 8'h01;
		if (mr_r[smrd_pkg::DLL_BIT])
			lock_nxt = LOCK_INIT;
		if (take && link.cmd == smrd_pkg::SMRD_LOAD && link.bank == 3'h0)
		begin
			if (link.addr[smrd_pkg::TM_BIT]) begin
				tm_nxt = 1'b1;
			end else begin
				mr_nxt = link.addr;
				tm_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mr_r   <= smrd_pkg::MR_RESET;
			tm_r   <= 1'b0;
			lock_r <= 8'h00;
		end else begin
			mr_r   <= mr_nxt;
			tm_r   <= tm_nxt;
			lock_r <= lock_nxt;
		end
	end

	// ------------------------------------------------------------
	// Burst sequencing
	// ------------------------------------------------------------
	assign act = (st_r == DS_WAIT && cnt_r == 4'h1) || st_r == DS_BURST;
	assign beat_idx = (st_r == DS_WAIT) ? 3'h0 : beat_r;

	smrd_burst_seq #(
		.COL_W      (COL_W)
	) u_seq (
		.start      (start_r),
		.beat       (beat_idx),
		.bl8        (burst_len8),
		.interleave (burst_interleave),
		.col        (col)
	);

	always_comb begin
		st_nxt     = st_r;
		cnt_nxt    = cnt_r;
		beat_nxt   = beat_r;
		start_nxt  = start_r;
		bank_nxt   = bank_r;
		wr_nxt     = wr_r;
		ap_nxt     = ap_r;
		apc_nxt    = (apc_r != 4'h0) ? apc_r - 4'h1 : apc_r;
		pre_nxt    = apc_r == 4'h1;
		rdata_nxt  = rdata_r;
		rvalid_nxt = 1'b0;
		case (st_r)
			DS_IDLE: begin
				if (take && (link.cmd == smrd_pkg::SMRD_READ ||
					link.cmd == smrd_pkg::SMRD_WRITE)) begin
					start_nxt = link.addr[COL_W-1:0];
					bank_nxt  = link.bank;
					wr_nxt    = link.cmd == smrd_pkg::SMRD_WRITE;
					ap_nxt    = link.cmd == smrd_pkg::SMRD_WRITE &&
						link.addr[smrd_pkg::AP_BIT];
					// first beat at n plus latency
					cnt_nxt   = smrd_pkg::smrd_lat(posted_extra_latency,
						column_latency, link.cmd == smrd_pkg::SMRD_WRITE);
					st_nxt    = DS_WAIT;
				end
			end
			DS_WAIT: begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1) begin
					beat_nxt = 3'h1;
					st_nxt   = DS_BURST;
				end
			end
			DS_BURST: begin
				beat_nxt = beat_r + 3'h1;
				if (beat_r == smrd_pkg::smrd_last(burst_len8)) begin
					st_nxt = DS_IDLE;
					if (ap_r)
						apc_nxt = recovery_cycles;
				end
			end
			default: st_nxt = DS_IDLE;
		endcase
		if (act && !wr_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = mem[col];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r     <= DS_IDLE;
			cnt_r    <= 4'h0;
			beat_r   <= 3'h0;
			start_r  <= '0;
			bank_r   <= 3'h0;
			wr_r     <= 1'b0;
			ap_r     <= 1'b0;
			apc_r    <= 4'h0;
			pre_r    <= 1'b0;
			rdata_r  <= '0;
			rvalid_r <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			cnt_r    <= cnt_nxt;
			beat_r   <= beat_nxt;
			start_r  <= start_nxt;
			bank_r   <= bank_nxt;
			wr_r     <= wr_nxt;
			ap_r     <= ap_nxt;
			apc_r    <= apc_nxt;
			pre_r    <= pre_nxt;
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// Array has no reset: contents are data, not control
	always_ff @(posedge pclk) begin
		if (act && wr_r)
			mem[col] <= link.wdata;
	end

	// ------------------------------------------------------------
	// Power-down and open rows
	// ------------------------------------------------------------
	always_comb begin
		open_nxt = open_r;
		pd_nxt   = pd_r;
		pda_nxt  = pda_r;
		pds_nxt  = pds_r;
		exit_nxt = (exit_r != 4'h0) ? exit_r - 4'h1 : exit_r;
		if (take && link.cmd == smrd_pkg::SMRD_ACT)
			open_nxt[link.bank] = 1'b1;
		if (take && link.cmd == smrd_pkg::SMRD_PRE) begin
			if (link.addr[smrd_pkg::AP_BIT])
				open_nxt = 8'h00;
			else
				open_nxt[link.bank] = 1'b0;
		end
		if (pre_r)
			open_nxt[bank_r] = 1'b0;
		if (!pd_r && !link.cke && st_r == DS_IDLE) begin
			pd_nxt  = 1'b1;
			pda_nxt = |open_r;
			pds_nxt = |open_r && powerdown_slow_exit;
		end else if (pd_r && link.cke) begin
			pd_nxt = 1'b0;
			if (!pda_r)
				exit_nxt = PRE_X;
			else if (pds_r)
				exit_nxt = SLOW_X;
			else
				exit_nxt = FAST_X;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_r <= 8'h00;
			pd_r   <= 1'b0;
			pda_r  <= 1'b0;
			pds_r  <= 1'b0;
			exit_r <= 4'h0;
		end else begin
			open_r <= open_nxt;
			pd_r   <= pd_nxt;
			pda_r  <= pda_nxt;
			pds_r  <= pds_nxt;
			exit_r <= exit_nxt;
		end
	end
endmodule : smrd_device

// >>> smrd_link_if.sv
// Purpose: Command, address and data link between controller and memory
// Assumes: Single pclk domain; one data beat per clock
// Notes:   No clocking block; the bench joins the two ends here
`timescale 1ns/1ps
interface smrd_link_if #(
	parameter int DATA_W = 16
);
	logic                    cke;
	smrd_pkg::smrd_cmd_t     cmd;
	logic [2:0]              bank;
	logic [12:0]             addr;
	logic [DATA_W-1:0]       wdata;
	logic [DATA_W-1:0]       rdata;
	logic                    rvalid;

	modport dev (input cke, cmd, bank, addr, wdata, output rdata, rvalid);
	modport ctl (output cke, cmd, bank, addr, wdata, input rdata, rvalid);
endinterface : smrd_link_if

// >>> smrd_pkg.sv
// Purpose: Shared constants and types for the mode-register decode link
// Assumes: 100 MHz pclk on both ends
// Notes:   Mode field layout follows the 13 address lines of a load
package smrd_pkg;

	// ------------------------------------------------------------
	// Mode register layout
	// ------------------------------------------------------------
	localparam int          MR_W        = 13;
	localparam int          BL_LSB      = 0;
	localparam int          BT_BIT      = 3;
	localparam int          LAT_LSB     = 4;
	localparam int          TM_BIT      = 7;
	localparam int          DLL_BIT     = 8;
	localparam int          WR_LSB      = 9;
	localparam int          PD_BIT      = 12;
	localparam int          AP_BIT      = 10;
	localparam logic [2:0]  BL8_CODE    = 3'h3;
	localparam logic [2:0]  LAT_MIN     = 3'h3;
	localparam logic [12:0] MR_RESET    = 13'h0232;

	// ------------------------------------------------------------
	// Timing counts
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int WR_TIME_NS      = 15;
	localparam int WR_CYC          =
		(WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLL_LOCK_CYC    = 200;
	localparam int MODE_LOAD_WAIT  = 2;
	localparam int FAST_EXIT_CYC   = 2;
	localparam int SLOW_EXIT_CYC   = 6;
	localparam int PRE_EXIT_CYC    = 2;

	// ------------------------------------------------------------
	// Controller registers
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_OFS   = 8'h00;
	localparam logic [7:0] ADDR_OFS  = 8'h04;
	localparam logic [7:0] WDATA_OFS = 8'h08;
	localparam logic [7:0] RDATA_OFS = 8'h0C;
	localparam logic [7:0] STAT_OFS  = 8'h10;
	localparam logic [7:0] CFG_OFS   = 8'h14;
	localparam int         CMD_BANK_LSB = 3;
	localparam int         CFG_PXL_LSB  = 1;

	typedef enum logic [2:0] {
		SMRD_NOP, SMRD_LOAD, SMRD_ACT, SMRD_READ, SMRD_WRITE, SMRD_PRE
	} smrd_cmd_t;

	// Cycles from command edge to first beat
	function automatic logic [3:0] smrd_lat(input logic [2:0] pxl,
		input logic [2:0] lat, input logic wr);
		smrd_lat = {1'b0, pxl} + {1'b0, lat} - {3'h0, wr};
	endfunction : smrd_lat

	function automatic logic [2:0] smrd_last(input logic bl8);
		smrd_last = bl8 ? 3'h7 : 3'h3;
	endfunction : smrd_last

endpackage : smrd_pkg

// >>> tb_top.sv
// Purpose: Controller end driven over APB, memory end over the link, beats checked
// Assumes: Posted latency set alike on both ends, reads gated by busy
// Notes:   Memory column c holds 0x100 plus c
`timescale 1ns/1ps
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic        rd_err, b8_w, il_w, lrp_w, pcs_w;
	logic [2:0]  lat_w, pxl_v;
	logic [3:0]  rc_w;
	logic [15:0] beats[$];
	int          bad_count, checks_done, cyc, t0, lat, pcnt;
	smrd_link_if #(.DATA_W(16)) lnk ();
	smrd_ctrl #(.DATA_W(16)) i_smrd_ctrl (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(lnk));
	smrd_device #(.COL_W(4), .DATA_W(16)) i_smrd_device (.pclk(pclk),
		.presetn(presetn), .link(lnk), .posted_extra_latency(pxl_v),
		.burst_len8(b8_w), .burst_interleave(il_w), .column_latency(lat_w),
		.recovery_cycles(rc_w), .powerdown_slow_exit(), .test_mode(),
		.loop_reset_pulse(lrp_w), .loop_locked(), .read_ready(),
		.loop_frozen(), .precharge_start(pcs_w));
	smrd_asserts i_smrd_asserts (.pclk(pclk), .presetn(presetn),
		.cke(lnk.cke), .cmd(lnk.cmd), .bank(lnk.bank), .addr(lnk.addr),
		.rvalid(lnk.rvalid), .posted_extra_latency(pxl_v), .burst_len8(b8_w),
		.burst_interleave(il_w), .column_latency(lat_w),
		.recovery_cycles(rc_w), .loop_reset_pulse(lrp_w),
		.precharge_start(pcs_w));
	always #5 pclk = ~pclk;
	// Beat collector; latency counted in sampling edges
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (lnk.cmd == smrd_pkg::SMRD_READ) t0 <= cyc;
		if (lnk.rvalid === 1'b1) begin
			if (beats.size() == 0) lat = cyc - t0;
			beats.push_back(lnk.rdata);
		end
		if (pcs_w === 1'b1) pcnt++;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("mismatch %s exp %h got %h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Hold the request until pready is seen high
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (n == 50) begin bad_count++; give_verdict(); end
	endtask : apb
	task issue(input logic [2:0] op, input logic [12:0] a);
		int n;
		apb(1'b1, smrd_pkg::ADDR_OFS, {19'h0, a});
		apb(1'b1, smrd_pkg::CMD_OFS, {29'h0, op});
		for (n = 0; n < 600; n++) begin
			apb(1'b0, smrd_pkg::STAT_OFS, 32'h0);
			if (rd_data[0] === 1'b0) break;
		end
		if (n == 600) begin bad_count++; give_verdict(); end
		// Busy drops before the last beat and the precharge pulse land
		repeat (8) @(posedge pclk);
	endtask : issue
	function automatic logic [3:0] exp_col(input logic [3:0] s,
		input logic [2:0] i, input logic b8, input logic il);
		logic [1:0] lo;
		lo = s[1:0] + i[1:0];
		if (il) exp_col = s ^ {1'b0, b8 & i[2], i[1:0]};
		else exp_col = {s[3], s[2] ^ (b8 & i[2]), lo};
	endfunction : exp_col
	initial begin
		logic b8, il;
		logic [2:0] lsel;
		logic [3:0] st;
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = 8'h00; pwdata = 32'h0; cyc = 0; t0 = 0; pcnt = 0;
		pxl_v = 3'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, smrd_pkg::CFG_OFS, 32'h1);
		issue(3'(smrd_pkg::SMRD_LOAD), 13'h0233);
		apb(1'b1, smrd_pkg::WDATA_OFS, 32'h100);
		issue(3'(smrd_pkg::SMRD_WRITE), 13'h0000);
		apb(1'b1, smrd_pkg::WDATA_OFS, 32'h108);
		issue(3'(smrd_pkg::SMRD_WRITE), 13'h0008);
		issue(3'(smrd_pkg::SMRD_LOAD), 13'h0232);
		apb(1'b1, smrd_pkg::WDATA_OFS, 32'h100);
		issue(3'(smrd_pkg::SMRD_WRITE), 13'h0400);
		chk("precharge", 32'h1, pcnt);
		$display("test write done");
		// Every length, order and latency, varied start
		for (int k = 0; k < 8; k++) begin
			b8 = k[0]; il = k[1]; lsel = 3'(3 + k % 5); st = 4'(k * 5 + 3);
			issue(3'(smrd_pkg::SMRD_LOAD),
				{4'h1, k == 0, 1'b0, lsel, il, 2'h1, b8});
			beats.delete();
			issue(3'(smrd_pkg::SMRD_READ), {9'h0, st});
			chk("beats", b8 ? 32'h8 : 32'h4, beats.size());
			chk("latency", 32'(lsel) + 1, lat);
			for (int i = 0; i < beats.size(); i++)
				chk("beat", 32'h100 + exp_col(st, 3'(i), b8, il),
					{16'h0, beats[i]});
			$display("test order %0d done", k);
		end
		// Posted hold of two clocks on both ends, last mode BL8 CL5
		pxl_v <= 3'h2;
		apb(1'b1, smrd_pkg::CFG_OFS, 32'h5);
		beats.delete();
		issue(3'(smrd_pkg::SMRD_READ), 13'h0005);
		chk("posted latency", 32'h8, lat);
		chk("posted beats", 32'h8, beats.size());
		chk("posted beat", 32'h105, {16'h0, beats[0]});
		$display("test posted done");
		// A load aimed at another mode register leaves this one alone
		apb(1'b1, smrd_pkg::ADDR_OFS, 32'h232);
		apb(1'b1, smrd_pkg::CMD_OFS,
			{26'h0, 3'h1, 3'(smrd_pkg::SMRD_LOAD)});
		repeat (8) @(posedge pclk);
		chk("bank select", 32'h5, {29'h0, lat_w});
		$display("test bank done");
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'h1, {31'h0, rd_err});
		give_verdict();
	end
endmodule : tb_top
